//--- hw/eeprom_pkg.sv
// Function
// - lock byte LSB shows page locked
// - same lock byte repeats while selected
// - lock read ignored during write cycle
// - lock data byte needs bit one set
// - lock only if select rises on boundary
// - accepted lock starts timed busy cycle
// - locked page drops write allow; fill ignores lock
// - lock dropped if busy or fully protected
// - no response before power-on reset ends
// - reset clears write latch and busy flag
// - reset keeps nonvolatile protect bits
// - after reset: standby, deselected, no hold
// - deselected device floats its data output
// - correction repairs one bit per group
// - byte write rewrites its whole group
// - delivery: ones, clear status, ident codes
// - status readable during write cycle
package eeprom_pkg;
	// opcodes as parameters
	// opcodes, values arbitrary
	localparam logic [7:0] READ_LOCK_STATE_OP = 8'h8b;
	localparam logic [7:0] FREEZE_IDENT_PAGE_OP = 8'h8a;
	// frame bit positions, counted from the first bit
	localparam logic [5:0] OPCODE_BITS = 6'd8;
	localparam logic [5:0] OPCODE_LAST_BIT = 6'd7;
	localparam logic [5:0] REGION_BIT_POS = 6'd13;
	localparam logic [5:0] ADDR_LAST_BIT = 6'd23;
	localparam logic [5:0] FIRST_DATA_BIT = 6'd24;
	localparam logic [5:0] LOCK_FLAG_POS = 6'd30;
	localparam logic [5:0] FRAME_REPEAT_BIT = 6'd32;
	localparam logic [5:0] FRAME_WRAP_BIT = 6'd39;
	localparam logic [2:0] LOCK_BIT_SLOT = 3'd7;
	// protection and delivery contents
	localparam logic [1:0] PROTECT_ALL = 2'b11;
	localparam logic [7:0] DELIVERY_BYTE = 8'hff;
	localparam logic [6:0] IDENT_CODE_BYTES = 7'd3;
	localparam logic [6:0] IDENT_LAST_BYTE = 7'd63;
	// correction code length in bit positions
	localparam int ECC_CODE_LEN = 38;
	// timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int SELF_TIMED_WRITE_TIME_NS = 5000000;
	localparam int WRITE_CYCLES = (SELF_TIMED_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOCK_WRITE = 2'b01,
		ST_FILL = 2'b10
	} core_state_t;

	typedef struct packed {logic write_in_progress; logic locked;} link_status_t;
	typedef struct packed {logic [31:0] data; logic [5:0] check;} ecc_word_t;
	typedef struct packed {logic valid; logic [1:0] lane; logic [7:0] data;} byte_write_t;

	typedef struct packed {
		logic [1:0] wip_s; logic [1:0] lck_s; logic [5:0] cnt; logic [7:0] op;
		logic busy; logic region; logic lock_flag; logic snap; logic drive; logic q; logic ready;
	} link_regs_t;

	typedef struct packed {
		logic rd_valid; logic [31:0] rd_data; logic fixed; logic wr_valid; ecc_word_t wr;
	} ecc_regs_t;

	typedef struct packed {
		logic [1:0] sel_s; logic sel_prev; logic [2:0] rdy_s; core_state_t st;
		logic write_in_progress; logic write_enable_latch; logic [23:0] tcnt; logic [23:0] busy_len; logic commit;
		logic allow; logic standby; logic [6:0] fill_idx; logic fill_wr;
		logic [5:0] fill_addr; logic [7:0] fill_data; logic stat_clr;
	} core_regs_t;

	localparam link_regs_t LINK_RESET = '0;
	localparam ecc_regs_t ECC_RESET = '0;
	localparam core_regs_t CORE_RESET = '{sel_s: 2'b11, sel_prev: 1'b1, standby: 1'b1, st: ST_IDLE, default: '0};
endpackage

//--- hw/spi_link.sv
`timescale 1ns/1ps
module spi_link
	import eeprom_pkg::*;
#(
	parameter logic [7:0] read_op = READ_LOCK_STATE_OP,
	parameter logic [7:0] freeze_op = FREEZE_IDENT_PAGE_OP
) (
	// link clock and resets
	input wire logic serial_clk_in,
	input wire logic nrst_in,
	input wire logic sel_n_in,
	// serial data
	input wire logic d_in,
	output logic q_out,
	output logic q_oe_n_out,
	// core side
	input wire link_status_t status_in,
	output logic lock_ready_out
);
	link_regs_t r, n;
	logic frame_rst_n;
	logic [5:0] cnt_nx;

	// frame state is cleared while chip select is high
	assign frame_rst_n = nrst_in & ~sel_n_in;

	// bit decode of one frame
	always_comb begin
		n = r;
		cnt_nx = (r.cnt == FRAME_WRAP_BIT) ? FRAME_REPEAT_BIT : r.cnt + 6'd1;
		n.wip_s = {r.wip_s[0], status_in.write_in_progress};
		n.lck_s = {r.lck_s[0], status_in.locked};
		n.cnt = cnt_nx;
		if (r.cnt < OPCODE_BITS) begin
			n.op = {r.op[6:0], d_in};
		end
		if (r.cnt == OPCODE_LAST_BIT) begin
			n.busy = r.wip_s[1];
		end
		if (r.cnt == REGION_BIT_POS) begin
			n.region = d_in;
		end
		if (r.cnt == LOCK_FLAG_POS) begin
			n.lock_flag = d_in;
		end
		if (r.cnt == ADDR_LAST_BIT) begin
			n.snap = r.lck_s[1];
		end
		n.drive = (r.op == read_op) && r.region && !r.busy && (cnt_nx >= FIRST_DATA_BIT);
		n.q = n.drive && (cnt_nx[2:0] == LOCK_BIT_SLOT) && n.snap;
		n.ready = (r.op == freeze_op) && r.region && !r.busy && n.lock_flag && (cnt_nx == FRAME_REPEAT_BIT);
	end

	// link registers
	always_ff @(posedge serial_clk_in or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			r <= LINK_RESET;
		end else begin
			r <= n;
		end
	end

	assign q_out = r.q;
	assign q_oe_n_out = ~r.drive;
	assign lock_ready_out = r.ready;

	chk_busy_silent: assert property (@(posedge serial_clk_in) disable iff (!frame_rst_n)
		r.busy |-> !r.drive) else $error("lock read answered while busy");
	chk_byte_repeat: assert property (@(posedge serial_clk_in) disable iff (!frame_rst_n)
		(r.drive && r.cnt >= FRAME_REPEAT_BIT) |-> r.q == $past(r.q, 8)) else $error("lock byte changed");
	chk_lock_lsb: assert property (@(posedge serial_clk_in) disable iff (!frame_rst_n)
		(r.drive && r.cnt[2:0] != LOCK_BIT_SLOT) |-> !r.q) else $error("upper lock byte bit set");
	chk_flag_needed: assert property (@(posedge serial_clk_in) disable iff (!frame_rst_n)
		r.ready |-> r.lock_flag && r.region) else $error("lock armed without data bit one");
endmodule // spi_link

//--- hw/ecc_group.sv
`timescale 1ns/1ps
module ecc_group
	import eeprom_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	// stored group and byte write
	input wire logic rd_valid_in,
	input wire ecc_word_t rd_word_in,
	input wire byte_write_t byte_wr_in,
	// results
	output logic rd_valid_out,
	output logic [31:0] rd_data_out,
	output logic rd_fixed_out,
	output logic wr_valid_out,
	output ecc_word_t wr_word_out
);
	ecc_regs_t r, n;
	logic [5:0] syn;
	logic [31:0] fixed;
	logic [31:0] merged;

	// check bits of a group, data at non power-of-two positions
	function automatic logic [5:0] check_bits(input logic [31:0] d);
		logic [5:0] c;
		int k;
		c = '0;
		k = 0;
		for (int p = 1; p <= ECC_CODE_LEN; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (d[k]) c = c ^ p[5:0];
				k++;
			end
		end
		return c;
	endfunction

	// flip the data bit the syndrome points at
	function automatic logic [31:0] fix_word(input logic [31:0] d, input logic [5:0] s);
		logic [31:0] f;
		int k;
		f = d;
		k = 0;
		for (int p = 1; p <= ECC_CODE_LEN; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (p[5:0] == s) f[k] = ~d[k];
				k++;
			end
		end
		return f;
	endfunction

	always_comb begin
		n = r;
		syn = check_bits(rd_word_in.data) ^ rd_word_in.check;
		fixed = fix_word(rd_word_in.data, syn);
		merged = fixed;
		merged[{byte_wr_in.lane, 3'b000} +: 8] = byte_wr_in.data;
		n.rd_valid = rd_valid_in;
		n.wr_valid = byte_wr_in.valid;
		if (rd_valid_in) begin
			n.rd_data = fixed;
			n.fixed = (syn != '0);
		end
		if (byte_wr_in.valid) begin
			n.wr.data = merged;
			n.wr.check = check_bits(merged);
		end
	end

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			r <= ECC_RESET;
		end else begin
			r <= n;
		end
	end

	assign rd_valid_out = r.rd_valid;
	assign rd_data_out = r.rd_data;
	assign rd_fixed_out = r.fixed;
	assign wr_valid_out = r.wr_valid;
	assign wr_word_out = r.wr;

	chk_group_rewrite: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		byte_wr_in.valid |=> wr_valid_out && check_bits(wr_word_out.data) == wr_word_out.check)
		else $error("group rewrite has bad check bits");
	chk_single_repair: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		rd_valid_in |=> rd_valid_out && rd_data_out == $past(fixed)) else $error("read not corrected");
endmodule // ecc_group

//--- hw/eeprom_lock_core.sv
`timescale 1ns/1ps
module eeprom_lock_core
	import eeprom_pkg::*;
#(
	// self-timed cycle length, shorten in simulation
	parameter int unsigned write_cycles = WRITE_CYCLES,
	// identity bytes, value arbitrary
	parameter logic [23:0] ident_code = 24'h5a3c96,
	// instruction codes
	parameter logic [7:0] read_op = READ_LOCK_STATE_OP,
	parameter logic [7:0] freeze_op = FREEZE_IDENT_PAGE_OP
) (
	// clock and power-on reset
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	// serial link pins
	input wire logic serial_clk_in,
	input wire logic sel_n_in,
	input wire logic d_in,
	output logic q_out,
	output logic q_oe_n_out,
	// nonvolatile status bits
	input wire logic protect_level_hi_in,
	input wire logic protect_level_lo_in,
	input wire logic ident_locked_in,
	// decoder side
	input wire logic write_latch_set_in,
	input wire logic fill_start_in,
	output logic write_in_progress_out,
	output logic write_enable_latch_out,
	output logic standby_out,
	output logic ident_write_allow_out,
	output logic lock_commit_out,
	output logic status_clear_out,
	// delivery fill of the ident page
	output logic fill_wr_valid_out,
	output logic [5:0] fill_wr_addr_out,
	output logic [7:0] fill_wr_data_out,
	// array group port
	input wire logic grp_rd_valid_in,
	input wire ecc_word_t grp_rd_word_in,
	input wire byte_write_t byte_wr_in,
	output logic grp_rd_valid_out,
	output logic [31:0] grp_rd_data_out,
	output logic grp_rd_fixed_out,
	output logic grp_wr_valid_out,
	output ecc_word_t grp_wr_word_out
);
	core_regs_t r, n;
	link_status_t link_status;
	logic lock_ready;
	logic cs_rise;
	logic prot_all;
	logic lock_ok;
	logic fill_last;

	// delivery contents of one ident page byte
	function automatic logic [7:0] delivery_byte(input logic [6:0] idx, input logic [23:0] code);
		logic [7:0] b;
		b = DELIVERY_BYTE;
		if (idx < IDENT_CODE_BYTES) b = code[{idx[1:0], 3'b000} +: 8];
		return b;
	endfunction

	// state shown to the link side
	assign link_status.write_in_progress = r.write_in_progress;
	assign link_status.locked = ident_locked_in;

	// serial front end on the link clock
	spi_link #(
		.read_op(read_op),
		.freeze_op(freeze_op)
	) u_link (
		.serial_clk_in(serial_clk_in),
		.nrst_in(nrst_in),
		.sel_n_in(sel_n_in),
		.d_in(d_in),
		.q_out(q_out),
		.q_oe_n_out(q_oe_n_out),
		.status_in(link_status),
		.lock_ready_out(lock_ready)
	);

	// four-byte correction groups
	ecc_group u_ecc (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.rd_valid_in(grp_rd_valid_in),
		.rd_word_in(grp_rd_word_in),
		.byte_wr_in(byte_wr_in),
		.rd_valid_out(grp_rd_valid_out),
		.rd_data_out(grp_rd_data_out),
		.rd_fixed_out(grp_rd_fixed_out),
		.wr_valid_out(grp_wr_valid_out),
		.wr_word_out(grp_wr_word_out)
	);

	// decode helpers
	assign cs_rise = r.sel_s[1] && !r.sel_prev;
	assign prot_all = ({protect_level_hi_in, protect_level_lo_in} == PROTECT_ALL);
	assign lock_ok = r.write_enable_latch && !r.write_in_progress && !prot_all;
	assign fill_last = (r.fill_idx == IDENT_LAST_BYTE);

	// next state of the lock and fill sequencer
	always_comb begin
		n = r;
		// chip select and ready level cross in; ready lags by one stage
		n.sel_s = {r.sel_s[0], sel_n_in};
		n.sel_prev = r.sel_s[1];
		n.rdy_s = {r.rdy_s[1:0], lock_ready};
		n.commit = 1'b0;
		n.fill_wr = 1'b0;
		n.stat_clr = 1'b0;
		n.allow = !ident_locked_in;
		unique case (r.st)
			ST_IDLE: begin
				if (cs_rise && r.rdy_s[2]) begin
					if (lock_ok) begin
						n.st = ST_LOCK_WRITE;
						n.write_in_progress = 1'b1;
						n.tcnt = '0;
						n.busy_len = 24'd1;
						n.write_enable_latch = 1'b0;
					end
				end else if (fill_start_in) begin
					n.st = ST_FILL;
					n.write_in_progress = 1'b1;
					n.fill_idx = '0;
				end
			end
			ST_LOCK_WRITE: begin
				if (r.tcnt == 24'(write_cycles - 1)) begin
					n.st = ST_IDLE;
					n.write_in_progress = 1'b0;
					n.commit = 1'b1;
				end else begin
					n.tcnt = r.tcnt + 24'd1;
					n.busy_len = r.busy_len + 24'd1;
				end
			end
			ST_FILL: begin
				n.fill_wr = 1'b1;
				n.fill_addr = r.fill_idx[5:0];
				n.fill_data = delivery_byte(r.fill_idx, ident_code);
				if (fill_last) begin
					n.st = ST_IDLE;
					n.write_in_progress = 1'b0;
					n.stat_clr = 1'b1;
				end else begin
					n.fill_idx = r.fill_idx + 7'd1;
				end
			end
			default: begin
				n.st = ST_IDLE;
				n.write_in_progress = 1'b0;
			end
		endcase
		// set wins over a clear in the same cycle
		if (write_latch_set_in) begin
			n.write_enable_latch = 1'b1;
		end
		n.standby = n.sel_s[1] && !n.write_in_progress;
	end

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			r <= CORE_RESET;
		end else begin
			r <= n;
		end
	end

	// registered outputs
	// status flags always readable
	assign write_in_progress_out = r.write_in_progress;
	assign write_enable_latch_out = r.write_enable_latch;
	assign standby_out = r.standby;
	assign ident_write_allow_out = r.allow;
	assign lock_commit_out = r.commit;
	assign status_clear_out = r.stat_clr;
	assign fill_wr_valid_out = r.fill_wr;
	assign fill_wr_addr_out = r.fill_addr;
	assign fill_wr_data_out = r.fill_data;

	// checks on the sequencer
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!nrst_in);

	sequence s_valid_rise;
		r.st == ST_IDLE && cs_rise && r.rdy_s[2];
	endsequence

	sequence s_locking;
		(r.st == ST_LOCK_WRITE && write_in_progress_out) [*3];
	endsequence

	property p_lock_starts;
		s_valid_rise ##0 lock_ok |=> s_locking;
	endproperty

	property p_dropped(cond);
		(r.st == ST_IDLE && cs_rise && cond) |=> r.st != ST_LOCK_WRITE;
	endproperty

	chk_lock_start: assert property (p_lock_starts)
		else $error("accepted lock did not start write");
	chk_partial_drop: assert property (p_dropped(!r.rdy_s[2]))
		else $error("lock ran without boundary");
	chk_protect_drop: assert property (p_dropped(prot_all))
		else $error("lock ran while fully protected");
	chk_latch_needed: assert property (p_dropped(!r.write_enable_latch))
		else $error("lock ran without write latch");
	chk_write_length: assert property (lock_commit_out |-> r.busy_len == 24'(write_cycles))
		else $error("write cycle length wrong");
	chk_reset_quiet: assert property (disable iff (1'b0)
		!nrst_in |-> !write_in_progress_out && !write_enable_latch_out && !lock_commit_out)
		else $error("flags not cleared in reset");
	chk_standby_state: assert property (disable iff (1'b0)
		$rose(nrst_in) |-> standby_out && !fill_wr_valid_out) else $error("not standby after reset");
	chk_read_only: assert property (ident_locked_in |=> !ident_write_allow_out)
		else $error("locked page still writable");
	chk_fill_ones: assert property ((fill_wr_valid_out && fill_wr_addr_out >= 6'(IDENT_CODE_BYTES))
		|-> fill_wr_data_out == DELIVERY_BYTE) else $error("delivery byte not all ones");
	chk_fill_end: assert property (status_clear_out |-> fill_wr_valid_out
		&& fill_wr_addr_out == IDENT_LAST_BYTE[5:0]) else $error("status cleared early");
	chk_nv_untouched: assert property ((r.st != ST_FILL) |=> !status_clear_out)
		else $error("nonvolatile bits touched");
	chk_float_deselect: assert property (r.sel_s[1] |-> q_oe_n_out)
		else $error("output driven while deselected");
	chk_busy_ignored: assert property ((r.write_in_progress && cs_rise) |=> !lock_commit_out ##1 !lock_commit_out)
		else $error("lock taken during write cycle");
endmodule // eeprom_lock_core

//--- tb/spi_master_model.sv
`timescale 1ns/1ps
module spi_master_model (
	// serial pins toward the memory
	output logic sclk_out,
	output logic sel_n_out,
	output logic d_out,
	// reply from the memory
	input wire logic q_in,
	input wire logic q_oe_n_in
);
	// idle: deselected, clock parked low
	initial begin
		sclk_out = 1'b0;
		sel_n_out = 1'b1;
		d_out = 1'b1;
	end

	// one frame, msb first, reply captured from edge 25 on
	task automatic frame(input logic [39:0] bits, input int n, output logic [15:0] rx, output logic oe_seen);
		rx = 16'h0000;
		oe_seen = 1'b0;
		#37;
		sel_n_out = 1'b0;
		for (int i = 0; i < n; i++) begin
			d_out = bits[39 - i];
			#80;
			if (i >= 24) begin
				// a released line reads as the inverse of q_in, which is low while released
				rx = {rx[14:0], (q_oe_n_in === 1'b0) ? q_in : ~q_in};
				if (q_oe_n_in === 1'b0) begin
					oe_seen = 1'b1;
				end
			end
			sclk_out = 1'b1;
			#80;
			sclk_out = 1'b0;
		end
		#80;
		// deselect, stale data not left on the line
		sel_n_out = 1'b1;
		d_out = ~d_out;
		#300;
	endtask
endmodule // spi_master_model

//--- tb/eeprom_lock_core_tb.sv
`timescale 1ns/1ps
module eeprom_lock_core_tb import eeprom_pkg::*; ;
	localparam int unsigned WR_N = 200;
	localparam logic [23:0] IDENT = 24'h1e2d4b; // arbitrary value
	logic ref_clk_in, nrst_in, sclk, sel_n, d, q, q_oe_n;
	logic prot_hi, prot_lo, locked, wl_set, fill_start, grp_valid;
	ecc_word_t grp_word, wr_word;
	byte_write_t byte_wr;
	logic write_in_progress, write_enable_latch, standby, allow, commit, clr, fill_v, rd_v, rd_fixed, wr_v;
	logic [5:0] fill_a;
	logic [7:0] fill_dat;
	logic [31:0] rd_data;
	logic [15:0] rx;
	logic oe_seen;
	int failures, cmp_count;
	int wip_run = 0;
	int wip_last = 0;

	// length of the last completed busy stretch, in ref cycles
	always @(posedge ref_clk_in) begin
		if (write_in_progress === 1'b1) begin
			wip_run <= wip_run + 1;
		end else begin
			if (wip_run != 0) begin
				wip_last <= wip_run;
			end
			wip_run <= 0;
		end
	end

	// clock and time-zero values
	initial begin
		ref_clk_in = 1'b0;
		nrst_in = 1'b0;
		{prot_hi, prot_lo, locked, wl_set, fill_start, grp_valid} = 6'h00;
		grp_word = '0;
		byte_wr = '0;
	end
	always #25 ref_clk_in = ~ref_clk_in;

	eeprom_lock_core #(.write_cycles(WR_N), .ident_code(IDENT)) u_dut (
		.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .serial_clk_in(sclk), .sel_n_in(sel_n), .d_in(d),
		.q_out(q), .q_oe_n_out(q_oe_n), .protect_level_hi_in(prot_hi), .protect_level_lo_in(prot_lo),
		.ident_locked_in(locked), .write_latch_set_in(wl_set), .fill_start_in(fill_start),
		.write_in_progress_out(write_in_progress), .write_enable_latch_out(write_enable_latch), .standby_out(standby),
		.ident_write_allow_out(allow), .lock_commit_out(commit), .status_clear_out(clr),
		.fill_wr_valid_out(fill_v), .fill_wr_addr_out(fill_a), .fill_wr_data_out(fill_dat),
		.grp_rd_valid_in(grp_valid), .grp_rd_word_in(grp_word), .byte_wr_in(byte_wr),
		.grp_rd_valid_out(rd_v), .grp_rd_data_out(rd_data), .grp_rd_fixed_out(rd_fixed),
		.grp_wr_valid_out(wr_v), .grp_wr_word_out(wr_word)
	);

	spi_master_model u_m (.sclk_out(sclk), .sel_n_out(sel_n), .d_out(d), .q_in(q), .q_oe_n_in(q_oe_n));

	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
		#5;
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// opcode, address with region bit, data byte
	task automatic send(input logic [7:0] op, input logic [15:0] addr, input logic [7:0] dat, input int n);
		u_m.frame({op, addr, dat, dat}, n, rx, oe_seen);
	endtask

	// write latch set before a lock
	task automatic latch();
		wl_set = 1'b1;
		cyc(1);
		wl_set = 1'b0;
		cyc(1);
	endtask

	task automatic wait_wip(input logic lvl);
		for (int k = 0; k < 400 && write_in_progress !== lvl; k++) cyc(1);
	endtask

	// lock state byte read, repeated byte and released output
	task automatic t_read(input logic lv);
		locked = lv;
		cyc(2);
		check(allow, !lv, "write allow");
		send(READ_LOCK_STATE_OP, 16'h0400, 8'h00, 40);
		check(rx, {7'h00, lv, 7'h00, lv}, "lock byte");
		check(oe_seen, 1'b1, "drive");
		check(q_oe_n, 1'b1, "float");
		locked = 1'b0;
	endtask

	// accepted lock on the 40-bit boundary, timed busy, commit
	task automatic t_accept();
		int k;
		latch();
		check(write_enable_latch, 1'b1, "latch");
		// only bit one of the data byte matters
		send(FREEZE_IDENT_PAGE_OP, 16'hfffe, 8'h02, 40);
		wait_wip(1'b1);
		check(write_in_progress, 1'b1, "busy start");
		check(write_enable_latch, 1'b0, "latch clear");
		k = 0;
		while (write_in_progress === 1'b1 && k < 400) begin
			k++;
			cyc(1);
		end
		check(commit, 1'b1, "commit");
		cyc(1);
		check(commit, 1'b0, "commit pulse");
		check(wip_last, WR_N, "busy length");
	endtask

	// refused lock variants
	task automatic t_refuse(input int n, input logic [7:0] dat, input logic [15:0] addr, input logic [1:0] p, input logic wl);
		{prot_hi, prot_lo} = p;
		if (wl) begin
			latch();
		end
		send(FREEZE_IDENT_PAGE_OP, addr, dat, n);
		cyc(10);
		check(write_in_progress, 1'b0, "refused lock");
		{prot_hi, prot_lo} = 2'b00;
	endtask

	// read during a write cycle is ignored
	task automatic t_busy();
		latch();
		send(FREEZE_IDENT_PAGE_OP, 16'h0400, 8'h02, 32);
		wait_wip(1'b1);
		send(READ_LOCK_STATE_OP, 16'h0400, 8'h00, 40);
		check(oe_seen, 1'b0, "busy read");
		check(rx, 16'hffff, "busy read line");
		wait_wip(1'b0);
		check(write_in_progress, 1'b0, "busy end");
	endtask

	// reset in the middle of a write cycle
	task automatic t_mid_reset();
		latch();
		send(FREEZE_IDENT_PAGE_OP, 16'h0400, 8'h02, 32);
		wait_wip(1'b1);
		latch();
		nrst_in = 1'b0;
		cyc(1);
		check({write_in_progress, write_enable_latch, standby, q_oe_n}, 4'h3, "reset state");
		nrst_in = 1'b1;
		cyc(4);
		check({write_in_progress, write_enable_latch, standby}, 3'h1, "after reset");
	endtask

	// single-bit repair and group rewrite
	task automatic t_ecc();
		grp_word = '{data: 32'h00000100, check: 6'h00};
		grp_valid = 1'b1;
		cyc(1);
		check({rd_v, rd_fixed}, 2'h3, "repair flag");
		check(rd_data, 32'h0, "repaired data");
		grp_word = '0;
		byte_wr = '{valid: 1'b1, lane: 2'd2, data: 8'hab};
		cyc(1);
		grp_valid = 1'b0;
		byte_wr = '0;
		check({rd_fixed, wr_v}, 2'h1, "group write");
		check(wr_word.data, 32'h00ab0000, "merged group");
		check(wr_word.check, 6'h1e, "group check bits");
	endtask

	// delivery contents of the ident page
	task automatic t_fill();
		int k;
		fill_start = 1'b1;
		cyc(1);
		fill_start = 1'b0;
		k = 0;
		for (int c = 0; c < 80; c++) begin
			if (fill_v === 1'b1) begin
				check(fill_a, k, "fill address");
				check(fill_dat, (k < 3) ? IDENT[8 * k +: 8] : DELIVERY_BYTE, "fill byte");
				check(clr, k == 63, "status clear");
				k++;
			end
			cyc(1);
		end
		check(k, 64, "fill count");
		check(write_in_progress, 1'b0, "fill end");
	endtask

	// main sequence
	initial begin
		failures = 0;
		cmp_count = 0;
		cyc(4);
		check({write_in_progress, write_enable_latch, standby, q_oe_n}, 4'h3, "power-on state");
		nrst_in = 1'b1;
		cyc(4);
		t_read(1'b0);
		t_read(1'b1);
		t_accept();
		t_refuse(32, 8'h02, 16'h0400, 2'b00, 1'b0);
		t_refuse(30, 8'h02, 16'h0400, 2'b00, 1'b1);
		t_refuse(32, 8'hfd, 16'h0400, 2'b00, 1'b0);
		t_refuse(32, 8'h02, 16'h0400, 2'b11, 1'b0);
		t_refuse(32, 8'h02, 16'hfbff, 2'b00, 1'b0);
		t_busy();
		t_mid_reset();
		t_ecc();
		t_fill();
		results();
	end

	// watchdog
	initial begin
		#1000000;
		failures++;
		results();
	end
endmodule // eeprom_lock_core_tb
